// >>> rtl/boot_readout_defs.svh
// offsets, field positions, reset values and timing counts of the readout block
// assumes a single 200 MHz clock; included by both design files
`ifndef BOOT_READOUT_DEFS_SVH
`define BOOT_READOUT_DEFS_SVH

// register offsets on the serial register port
`define REG_STATUS 8'h00
`define REG_DIE_TEMPERATURE 8'h01
`define REG_MAGNITUDE_LOW 8'h02
`define REG_MAGNITUDE_HIGH 8'h03
`define REG_SENSOR_CONFIG_TWO 8'h16
`define REG_SENSOR_CONFIG_FOUR 8'h18
`define REG_SENSOR_CONFIG_FIVE 8'h19
`define REG_IRQ_ENABLE 8'h20
`define REG_IRQ_ROUTE 8'h21

// field positions
`define STATUS_BOOT_DONE_BIT 0
`define STATUS_DATA_READY_BIT 7
`define CFG_TWO_BYTE_ORDER_BIT 0
`define CFG_FOUR_POLARITY_BIT 0
`define CFG_FOUR_DRIVER_BIT 1
`define CFG_FIVE_MAG_ENABLE_BIT 4
`define IRQ_ENABLE_BOOT_BIT 0
`define IRQ_ROUTE_BOOT_BIT 0

// reset values
`define SENSOR_CONFIG_TWO_RESET 8'h00
`define SENSOR_CONFIG_FOUR_RESET 8'h01
`define SENSOR_CONFIG_FIVE_RESET 8'h00
`define IRQ_ENABLE_RESET 8'h01
`define IRQ_ROUTE_RESET 8'h00
`define MAGNITUDE_RESET 12'h000
`define TEMPERATURE_RESET 8'h00

// timing: figures in their own unit, counts derived from the clock rate
`define CLK_MHZ 200
`define BOOT_TIME_US 500
`define BOOT_TIME_CYCLES (`BOOT_TIME_US * `CLK_MHZ)
`define BOOT_PULSE_SHORT_US 10
`define BOOT_PULSE_SHORT_CYCLES (`BOOT_PULSE_SHORT_US * `CLK_MHZ)
`define BOOT_PULSE_LONG_MS 1
`define BOOT_PULSE_LONG_CYCLES (`BOOT_PULSE_LONG_MS * 1000 * `CLK_MHZ)

// magnitude arithmetic
`define MAG_ROOT_BITS 12
`define MAG_SUM_BITS 24

`endif

// >>> rtl/boot_readout_pkg.sv
// types shared by the readout block and its magnitude unit
// assumes nothing beyond a SystemVerilog compiler
package boot_readout_pkg;

  // boot sequencer states
  typedef enum logic [1:0]
  {
    boot_run = 2'b00,
    boot_pulse = 2'b01,
    boot_idle = 2'b10
  } boot_state_type;

  // magnitude unit states
  typedef enum logic [0:0]
  {
    mag_idle = 1'b0,
    mag_calc = 1'b1
  } mag_state_type;

endpackage

// >>> rtl/vector_magnitude_unit.sv
// iterative 12-bit square root of the sum of squared axis samples
// assumes start only while busy is low; result holds until the next done
`include "boot_readout_defs.svh"

module vector_magnitude_unit
  import boot_readout_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // request
  input wire logic start,
  input wire logic signed [11:0] x_sample,
  input wire logic signed [11:0] y_sample,
  input wire logic signed [11:0] z_sample,
  // answer
  output logic busy,
  output logic done,
  output logic [11:0] vector_magnitude
);

  mag_state_type state_reg;
  logic [`MAG_SUM_BITS-1:0] sum_reg;
  logic [`MAG_ROOT_BITS-1:0] root_reg;
  logic [3:0] bit_reg;
  logic [`MAG_ROOT_BITS-1:0] trial;
  logic [`MAG_SUM_BITS-1:0] trial_square;

  // square of a signed axis sample, widened to the sum width
  function automatic logic [`MAG_SUM_BITS-1:0] axis_square(input logic signed [11:0] value);
    logic [11:0] mag;
    mag = value[11] ? 12'(-value) : 12'(value);
    // widen before the product so no upper bits are lost
    axis_square = `MAG_SUM_BITS'(mag) * `MAG_SUM_BITS'(mag);
  endfunction

  // one result bit per cycle keeps the multiplier small
  assign trial = root_reg | (`MAG_ROOT_BITS'(1) << bit_reg);
  assign trial_square = `MAG_SUM_BITS'(trial) * `MAG_SUM_BITS'(trial);
  assign busy = (state_reg == mag_calc);

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= mag_idle;
      sum_reg <= '0;
      root_reg <= '0;
      bit_reg <= 4'h0;
      done <= 1'b0;
      vector_magnitude <= `MAGNITUDE_RESET;
    end
    else
    begin
      done <= 1'b0;
      case (state_reg)
        mag_idle:
        begin
          if (start)
          begin
            sum_reg <= axis_square(x_sample) + axis_square(y_sample) + axis_square(z_sample);
            root_reg <= '0;
            bit_reg <= 4'hb;
            state_reg <= mag_calc;
          end
        end
        mag_calc:
        begin
          if (trial_square <= sum_reg)
          begin
            root_reg <= trial;
          end
          if (bit_reg == 4'h0)
          begin
            vector_magnitude <= (trial_square <= sum_reg) ? trial : root_reg;
            done <= 1'b1;
            state_reg <= mag_idle;
          end
          else
          begin
            bit_reg <= bit_reg - 4'h1;
          end
        end
        default:
        begin
          state_reg <= mag_idle;
        end
      endcase
    end
  end

endmodule

// >>> rtl/boot_temp_magnitude_readout.sv
// boot-complete flag and boot pulse, temperature result and vector magnitude result
// assumes a serial front end turning frames into one-cycle register strobes on mclk,
// and an acquisition path giving one sample strobe per output data rate cycle
`include "boot_readout_defs.svh"

module boot_temp_magnitude_readout
  import boot_readout_pkg::*;
#(
  parameter int BOOT_CYCLES = `BOOT_TIME_CYCLES,
  parameter int SHORT_PULSE_CYCLES = `BOOT_PULSE_SHORT_CYCLES,
  parameter int LONG_PULSE_CYCLES = `BOOT_PULSE_LONG_CYCLES
)
(
  // clock and power-on reset
  input wire logic mclk,
  input wire logic reset,
  // boot triggers besides power-on, one-cycle pulses on mclk
  input wire logic soft_reset,
  input wire logic hibernate_exit,
  // strap pin, asynchronous
  input wire logic boot_mode_strap,
  // register port strobes from the serial front end
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  output logic reg_refused,
  // one sample per output data rate cycle
  input wire logic sample_valid,
  input wire logic [7:0] temp_sample,
  input wire logic signed [11:0] x_sample,
  input wire logic signed [11:0] y_sample,
  input wire logic signed [11:0] z_sample,
  // interrupt pins, output and enable each
  output logic irq_pin_one_out,
  output logic irq_pin_one_oe,
  output logic irq_pin_two_out,
  output logic irq_pin_two_oe
);

  boot_state_type boot_state_reg;
  logic [31:0] boot_count_reg;
  logic boot_done_reg;
  logic strap_meta_reg;
  logic strap_sync_reg;
  logic pulse_active_reg;
  logic pulse_on_two_reg;
  logic pulse_high_reg;
  logic pulse_open_drain_reg;
  logic [7:0] sensor_config_two_reg;
  logic [7:0] sensor_config_four_reg;
  logic [7:0] sensor_config_five_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_route_reg;
  logic [7:0] die_temperature_reg;
  logic [7:0] temp_pending_reg;
  logic mag_pending_reg;
  logic [11:0] magnitude_reg;
  logic data_ready_reg;
  logic boot_trigger;
  logic host_read;
  logic host_write;
  logic sample_take;
  logic mag_start;
  logic mag_busy;
  logic mag_done;
  logic [11:0] mag_result;
  logic result_latch;
  logic mag_read;

  // byte view of the magnitude at an offset, in the selected byte order
  function automatic logic [7:0] magnitude_byte(input logic [11:0] mag, input logic big_endian,
                                                input logic high_addr);
    if (big_endian)
    begin
      magnitude_byte = high_addr ? {mag[3:0], 4'h0} : mag[11:4];
    end
    else
    begin
      magnitude_byte = high_addr ? {4'h0, mag[11:8]} : mag[7:0];
    end
  endfunction

  // boot triggers other than power-on reset restart the sequence
  assign boot_trigger = soft_reset | hibernate_exit;

  assign host_read = reg_rd & boot_done_reg;
  assign host_write = reg_wr & ~reg_rd & boot_done_reg;

  assign mag_read = host_read & ((reg_addr == `REG_MAGNITUDE_LOW) | (reg_addr == `REG_MAGNITUDE_HIGH));

  // a sample arriving while the previous magnitude is still in work is dropped;
  // busy also covers a calculation orphaned by a boot trigger, whose result is stale
  assign sample_take = sample_valid & boot_done_reg & ~boot_trigger & ~mag_pending_reg & ~mag_busy;

  assign mag_start = sample_take & sensor_config_five_reg[`CFG_FIVE_MAG_ENABLE_BIT];

  // results land either at once or when the magnitude unit finishes
  assign result_latch = (sample_take & ~sensor_config_five_reg[`CFG_FIVE_MAG_ENABLE_BIT])
                      | (mag_pending_reg & mag_done);

  // strap synchroniser; only the second stage is read
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      strap_meta_reg <= 1'b0;
      strap_sync_reg <= 1'b0;
    end
    else
    begin
      strap_meta_reg <= boot_mode_strap;
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // boot sequencer: run, one pulse if strapped or the boot irq is enabled, then idle until the next trigger
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      boot_state_reg <= boot_run;
      boot_count_reg <= 32'h0000_0000;
      boot_done_reg <= 1'b0;
      pulse_active_reg <= 1'b0;
      pulse_on_two_reg <= 1'b0;
      pulse_high_reg <= 1'b0;
      pulse_open_drain_reg <= 1'b0;
    end
    else if (boot_trigger)
    begin
      boot_state_reg <= boot_run;
      boot_count_reg <= 32'h0000_0000;
      boot_done_reg <= 1'b0;
      pulse_active_reg <= 1'b0;
    end
    else
    begin
      case (boot_state_reg)
        boot_run:
        begin
          if (boot_count_reg >= 32'(BOOT_CYCLES - 1))
          begin
            boot_done_reg <= 1'b1;
            boot_count_reg <= 32'h0000_0000;
            if (strap_sync_reg)
            begin
              boot_state_reg <= boot_pulse;
              pulse_active_reg <= 1'b1;
              pulse_on_two_reg <= 1'b1;
              pulse_high_reg <= 1'b0;
              pulse_open_drain_reg <= 1'b1;
            end
            else if (irq_enable_reg[`IRQ_ENABLE_BOOT_BIT])
            begin
              boot_state_reg <= boot_pulse;
              pulse_active_reg <= 1'b1;
              pulse_on_two_reg <= irq_route_reg[`IRQ_ROUTE_BOOT_BIT];
              pulse_high_reg <= sensor_config_four_reg[`CFG_FOUR_POLARITY_BIT];
              pulse_open_drain_reg <= sensor_config_four_reg[`CFG_FOUR_DRIVER_BIT];
            end
            else
            begin
              boot_state_reg <= boot_idle;
            end
          end
          else
          begin
            boot_count_reg <= boot_count_reg + 32'h0000_0001;
          end
        end
        boot_pulse:
        begin
          if ((pulse_on_two_reg & pulse_open_drain_reg & ~pulse_high_reg & strap_sync_reg)
              ? (boot_count_reg >= 32'(LONG_PULSE_CYCLES - 1))
              : (boot_count_reg >= 32'(SHORT_PULSE_CYCLES - 1)))
          begin
            pulse_active_reg <= 1'b0;
            boot_state_reg <= boot_idle;
          end
          else
          begin
            boot_count_reg <= boot_count_reg + 32'h0000_0001;
          end
        end
        boot_idle:
        begin
          pulse_active_reg <= 1'b0;
        end
        default:
        begin
          boot_state_reg <= boot_idle;
          pulse_active_reg <= 1'b0;
        end
      endcase
    end
  end

  // pin drivers; open drain only ever pulls low, the pull-up lives outside
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      irq_pin_one_out <= 1'b0;
      irq_pin_one_oe <= 1'b0;
      irq_pin_two_out <= 1'b0;
      irq_pin_two_oe <= 1'b0;
    end
    else
    begin
      if (pulse_open_drain_reg)
      begin
        irq_pin_one_out <= 1'b0;
        irq_pin_one_oe <= pulse_active_reg & ~pulse_on_two_reg;
        irq_pin_two_out <= 1'b0;
        irq_pin_two_oe <= pulse_active_reg & pulse_on_two_reg;
      end
      else
      begin
        irq_pin_one_out <= (pulse_active_reg & ~pulse_on_two_reg) ? pulse_high_reg : ~pulse_high_reg;
        irq_pin_one_oe <= boot_done_reg;
        irq_pin_two_out <= (pulse_active_reg & pulse_on_two_reg) ? pulse_high_reg : ~pulse_high_reg;
        irq_pin_two_oe <= boot_done_reg;
      end
    end
  end

  // settings kept across soft reset; power-on and hibernate exit restore them
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sensor_config_four_reg <= `SENSOR_CONFIG_FOUR_RESET;
      irq_route_reg <= `IRQ_ROUTE_RESET;
    end
    else if (hibernate_exit)
    begin
      sensor_config_four_reg <= `SENSOR_CONFIG_FOUR_RESET;
      irq_route_reg <= `IRQ_ROUTE_RESET;
    end
    else if (host_write)
    begin
      if (reg_addr == `REG_SENSOR_CONFIG_FOUR)
      begin
        sensor_config_four_reg <= reg_wdata;
      end
      if (reg_addr == `REG_IRQ_ROUTE)
      begin
        irq_route_reg <= reg_wdata;
      end
    end
  end

  // settings that any boot trigger restores
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sensor_config_two_reg <= `SENSOR_CONFIG_TWO_RESET;
      sensor_config_five_reg <= `SENSOR_CONFIG_FIVE_RESET;
      irq_enable_reg <= `IRQ_ENABLE_RESET;
    end
    else if (boot_trigger)
    begin
      sensor_config_two_reg <= `SENSOR_CONFIG_TWO_RESET;
      sensor_config_five_reg <= `SENSOR_CONFIG_FIVE_RESET;
      irq_enable_reg <= `IRQ_ENABLE_RESET;
    end
    else if (host_write)
    begin
      if (reg_addr == `REG_SENSOR_CONFIG_TWO)
      begin
        sensor_config_two_reg <= reg_wdata;
      end
      if (reg_addr == `REG_SENSOR_CONFIG_FIVE)
      begin
        sensor_config_five_reg <= reg_wdata;
      end
      if (reg_addr == `REG_IRQ_ENABLE)
      begin
        irq_enable_reg <= reg_wdata;
      end
    end
  end

  vector_magnitude_unit magnitude_unit
  (
    .mclk(mclk),
    .reset(reset),
    .start(mag_start),
    .x_sample(x_sample),
    .y_sample(y_sample),
    .z_sample(z_sample),
    .busy(mag_busy),
    .done(mag_done),
    .vector_magnitude(mag_result)
  );

  // result registers: temperature waits for the magnitude so both land together
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      die_temperature_reg <= `TEMPERATURE_RESET;
      temp_pending_reg <= `TEMPERATURE_RESET;
      mag_pending_reg <= 1'b0;
      magnitude_reg <= `MAGNITUDE_RESET;
    end
    else if (boot_trigger)
    begin
      magnitude_reg <= `MAGNITUDE_RESET;
      mag_pending_reg <= 1'b0;
    end
    else
    begin
      if (mag_start)
      begin
        temp_pending_reg <= temp_sample;
        mag_pending_reg <= 1'b1;
      end
      else if (mag_pending_reg & mag_done)
      begin
        mag_pending_reg <= 1'b0;
      end
      if (result_latch)
      begin
        die_temperature_reg <= mag_pending_reg ? temp_pending_reg : temp_sample;
        if (mag_pending_reg)
        begin
          magnitude_reg <= mag_result;
        end
      end
    end
  end

  // data-ready flag; a new result in the same cycle as a clearing read wins
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      data_ready_reg <= 1'b0;
    end
    else if (boot_trigger)
    begin
      data_ready_reg <= 1'b0;
    end
    else if (result_latch)
    begin
      data_ready_reg <= 1'b1;
    end
    else if (mag_read)
    begin
      data_ready_reg <= 1'b0;
    end
  end

  // register port answer, one cycle after the strobe
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
      reg_ack <= 1'b0;
      reg_refused <= 1'b0;
    end
    else
    begin
      reg_ack <= host_read | host_write;
      reg_refused <= (reg_rd | reg_wr) & ~boot_done_reg;
      if (host_read)
      begin
        case (reg_addr)
          `REG_STATUS:
          begin
            reg_rdata <= {data_ready_reg, 6'h00, boot_done_reg};
          end
          `REG_DIE_TEMPERATURE:
          begin
            reg_rdata <= die_temperature_reg;
          end
          `REG_MAGNITUDE_LOW:
          begin
            reg_rdata <= magnitude_byte(magnitude_reg, sensor_config_two_reg[`CFG_TWO_BYTE_ORDER_BIT], 1'b0);
          end
          `REG_MAGNITUDE_HIGH:
          begin
            reg_rdata <= magnitude_byte(magnitude_reg, sensor_config_two_reg[`CFG_TWO_BYTE_ORDER_BIT], 1'b1);
          end
          `REG_SENSOR_CONFIG_TWO:
          begin
            reg_rdata <= sensor_config_two_reg;
          end
          `REG_SENSOR_CONFIG_FOUR:
          begin
            reg_rdata <= sensor_config_four_reg;
          end
          `REG_SENSOR_CONFIG_FIVE:
          begin
            reg_rdata <= sensor_config_five_reg;
          end
          `REG_IRQ_ENABLE:
          begin
            reg_rdata <= irq_enable_reg;
          end
          `REG_IRQ_ROUTE:
          begin
            reg_rdata <= irq_route_reg;
          end
          default:
          begin
            // unmapped offsets read as zero
            reg_rdata <= 8'h00;
          end
        endcase
      end
      else
      begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule

// >>> sim/boot_readout_checker_assertions.sv
// assertions on the ports of the boot, temperature and magnitude readout block
// assumes a bind from the bench top file, with the bench's short counts passed on
`include "boot_readout_defs.svh"

module boot_readout_checker
#(
  parameter int BOOT_CYCLES = 20,
  parameter int SHORT_PULSE_CYCLES = 5,
  parameter int LONG_PULSE_CYCLES = 8
)
(
  // clock, reset and boot triggers
  input wire logic mclk, reset, soft_reset, hibernate_exit, boot_mode_strap,
  // register port
  input wire logic reg_rd, reg_wr, reg_ack, reg_refused,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  // samples
  input wire logic sample_valid,
  input wire logic [7:0] temp_sample,
  input wire logic signed [11:0] x_sample, y_sample, z_sample,
  // interrupt pins
  input wire logic irq_pin_one_out, irq_pin_one_oe, irq_pin_two_out, irq_pin_two_oe
);
  logic [15:0] boot_cnt;
  logic [15:0] one_cnt;
  logic [15:0] two_cnt;
  logic be_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // edges since the last boot trigger, saturating so it never wraps
  always_ff @(posedge mclk or posedge reset)
    if (reset) boot_cnt <= '0;
    else if (soft_reset || hibernate_exit) boot_cnt <= '0;
    else if (boot_cnt != 16'hffff) boot_cnt <= boot_cnt + 16'h1;

  // length of the current active stretch on each pin
  always_ff @(posedge mclk or posedge reset)
    if (reset) one_cnt <= '0;
    else one_cnt <= (irq_pin_one_oe && irq_pin_one_out) ? one_cnt + 16'h1 : 16'h0;
  always_ff @(posedge mclk or posedge reset)
    if (reset) two_cnt <= '0;
    else two_cnt <= (irq_pin_two_oe && !irq_pin_two_out) ? two_cnt + 16'h1 : 16'h0;

  // byte order as last written; both triggers return it to little-endian
  always_ff @(posedge mclk or posedge reset)
    if (reset) be_reg <= 1'b0;
    else if (soft_reset || hibernate_exit) be_reg <= 1'b0;
    else if (reg_ack && $past(reg_wr) && !$past(reg_rd) && $past(reg_addr) == `REG_SENSOR_CONFIG_TWO)
      be_reg <= $past(reg_wdata[`CFG_TWO_BYTE_ORDER_BIT]);

  chk_strobe_answered: assert property ((reg_rd || reg_wr) |=> (reg_ack != reg_refused))
    else $error("strobe without exactly one answer");
  chk_no_stray: assert property (!(reg_rd || reg_wr) |=> !reg_ack && !reg_refused)
    else $error("answer without a strobe");
  chk_refused_early: assert property (reg_refused |-> boot_cnt <= BOOT_CYCLES + 1)
    else $error("access refused after boot end");
  chk_ack_late: assert property (reg_ack |-> boot_cnt > BOOT_CYCLES && reg_refused == 1'b0)
    else $error("access accepted during boot");
  chk_done_sticky: assert property ((reg_rd || reg_wr) && boot_cnt >= BOOT_CYCLES |=> reg_ack)
    else $error("boot done lost without trigger");
  chk_quiet_boot: assert property (boot_cnt > 2 && boot_cnt < BOOT_CYCLES |-> !irq_pin_one_oe && !irq_pin_two_oe)
    else $error("pin driven during boot");
  chk_one_width: assert property ($fell(irq_pin_one_oe && irq_pin_one_out) && boot_cnt > 2
    |-> one_cnt == SHORT_PULSE_CYCLES)
    else $error("pin one pulse width wrong");
  chk_two_width: assert property ($fell(irq_pin_two_oe && !irq_pin_two_out) && boot_cnt > 2
    |-> two_cnt == (boot_mode_strap ? LONG_PULSE_CYCLES : SHORT_PULSE_CYCLES))
    else $error("pin two pulse width wrong");
  chk_high_nibble: assert property (reg_ack && $past(reg_rd) && $past(reg_addr) == `REG_MAGNITUDE_HIGH
    |-> (be_reg ? reg_rdata[3:0] : reg_rdata[7:4]) == 4'h0)
    else $error("magnitude high byte unused nibble set");

  cov_refused: cover property (reg_refused);
  cov_mag_read: cover property (reg_ack && $past(reg_addr) == `REG_MAGNITUDE_LOW && be_reg);
  cov_long_pulse: cover property ($fell(irq_pin_two_oe) && boot_mode_strap);
endmodule

// >>> sim/host_model.sv
// host processor on the register port, plus the board wiring of both irq pins
// assumes one-cycle strobes launched at the falling edge of mclk
module host_model
(
  // clock
  input wire logic mclk,
  // register port
  output logic reg_rd, reg_wr,
  output logic [7:0] reg_addr, reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack, reg_refused,
  // pins and their board level
  input wire logic irq_pin_one_out, irq_pin_one_oe, irq_pin_two_out, irq_pin_two_oe,
  output logic pin_one_level, pin_two_level
);
  timeunit 1ns;
  timeprecision 1ps;

  assign pin_two_level = irq_pin_two_oe ? irq_pin_two_out : 1'b1;
  // pin one has a pull-down on this board
  assign pin_one_level = irq_pin_one_oe ? irq_pin_one_out : 1'b0;

  initial
  begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one access; the answer is taken one cycle after the strobe edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    @(negedge mclk);
    reg_rd = !wr;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    // released lines carry junk, never the old value
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
    ok = reg_ack;
  endtask
endmodule

// >>> sim/tb.sv
// self-checking bench: boot flag and pulses, temperature and magnitude results
// assumes design, checker and host model compiled before this file
`include "boot_readout_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BOOT = 20;
  localparam int SHORT = 5;
  localparam int LONG = 8;
  logic mclk, reset, soft_reset, hibernate_exit, boot_mode_strap, sample_valid;
  logic reg_rd, reg_wr, reg_ack, reg_refused, ok, pin_one_level, pin_two_level;
  logic irq_pin_one_out, irq_pin_one_oe, irq_pin_two_out, irq_pin_two_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, temp_sample, q;
  logic signed [11:0] x_sample, y_sample, z_sample;
  logic [11:0] m;
  int failures, samples_checked, hi1, lo2, seed;

  boot_temp_magnitude_readout #(.BOOT_CYCLES(BOOT), .SHORT_PULSE_CYCLES(SHORT), .LONG_PULSE_CYCLES(LONG)) dut_u (.*);
  host_model host_u (.*);

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // active time on the board wires; reset by hand before each pulse
  always @(posedge mclk)
  begin
    hi1 <= hi1 + int'(pin_one_level);
    lo2 <= lo2 + int'(!pin_two_level);
  end

  task automatic finish_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host_u.access(1'b0, a, 8'h00, q, ok);
    check({7'h0, ok}, 8'h01);
    check(q, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(1'b1, a, d, q, ok);
    check({7'h0, ok}, 8'h01);
  endtask

  // polls status; a bound that runs out counts a mismatch
  task automatic boot_wait();
    int n;
    n = 0;
    ok = 1'b0;
    while (ok !== 1'b1 && n < 40)
    begin
      host_u.access(1'b0, `REG_STATUS, 8'h00, q, ok);
      n++;
    end
    if (ok !== 1'b1)
    begin
      failures++;
      $display("MISMATCH t=%0t boot never completed", $time);
    end
    repeat (12) @(negedge mclk);
  endtask

  // one-cycle trigger, then clear the pin-two tally once the pins are off
  task automatic trigger(input logic is_soft);
    @(negedge mclk);
    soft_reset = is_soft;
    hibernate_exit = !is_soft;
    @(negedge mclk);
    soft_reset = 1'b0;
    hibernate_exit = 1'b0;
    repeat (3) @(negedge mclk);
    lo2 = 0;
  endtask

  // first call uses the largest negative axes, the rest random
  task automatic send(input int i);
    @(negedge mclk);
    sample_valid = 1'b1;
    temp_sample = 8'($random(seed));
    x_sample = (i == 0) ? 12'h800 : 12'($random(seed));
    y_sample = (i == 0) ? 12'h800 : 12'($random(seed));
    z_sample = (i == 0) ? 12'h800 : 12'($random(seed));
    @(negedge mclk);
    sample_valid = 1'b0;
    repeat (16) @(negedge mclk);
  endtask

  function automatic logic [11:0] isqrt(input logic signed [11:0] x, y, z);
    int s;
    int r;
    s = x * x + y * y + z * z;
    r = 0;
    while ((r + 1) * (r + 1) <= s)
      r++;
    return r[11:0];
  endfunction

  initial
  begin
    seed = 45652;
    failures = 0;
    samples_checked = 0;
    hi1 = 0;
    lo2 = 0;
    reset = 1'b1;
    soft_reset = 1'b0;
    hibernate_exit = 1'b0;
    boot_mode_strap = 1'b0;
    sample_valid = 1'b0;
    temp_sample = 8'h00;
    x_sample = 12'h000;
    y_sample = 12'h000;
    z_sample = 12'h000;
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    host_u.access(1'b0, `REG_MAGNITUDE_LOW, 8'h00, q, ok);
    check({6'h0, reg_refused, ok}, 8'h02);
    boot_wait();
    check(q & 8'h01, 8'h01);
    check(8'(hi1), 8'(SHORT));
    rd(`REG_MAGNITUDE_LOW, 8'h00);
    rd(`REG_MAGNITUDE_HIGH, 8'h00);
    wr(`REG_DIE_TEMPERATURE, 8'h5a);
    rd(`REG_DIE_TEMPERATURE, 8'h00);
    wr(`REG_SENSOR_CONFIG_FIVE, 8'h10);
    for (int i = 0; i < 8; i++)
    begin
      wr(`REG_SENSOR_CONFIG_TWO, {7'h0, i[0]});
      send(i);
      m = isqrt(x_sample, y_sample, z_sample);
      rd(`REG_STATUS, 8'h81);
      rd(`REG_DIE_TEMPERATURE, temp_sample);
      rd(`REG_MAGNITUDE_LOW, i[0] ? m[11:4] : m[7:0]);
      rd(`REG_STATUS, 8'h01);
      rd(`REG_MAGNITUDE_HIGH, i[0] ? {m[3:0], 4'h0} : {4'h0, m[11:8]});
    end
    wr(`REG_SENSOR_CONFIG_FIVE, 8'h00);
    send(1);
    rd(`REG_DIE_TEMPERATURE, temp_sample);
    rd(`REG_MAGNITUDE_HIGH, {m[3:0], 4'h0});
    wr(`REG_SENSOR_CONFIG_FOUR, 8'h02);
    wr(`REG_IRQ_ROUTE, 8'h01);
    trigger(1'b1);
    boot_wait();
    check(8'(lo2), 8'(SHORT));
    rd(`REG_SENSOR_CONFIG_FOUR, 8'h02);
    rd(`REG_SENSOR_CONFIG_TWO, 8'h00);
    boot_mode_strap = 1'b1;
    trigger(1'b0);
    boot_wait();
    check(8'(lo2), 8'(LONG));
    rd(`REG_SENSOR_CONFIG_FOUR, `SENSOR_CONFIG_FOUR_RESET);
    finish_test();
  end
endmodule

bind boot_temp_magnitude_readout boot_readout_checker #(.BOOT_CYCLES(BOOT_CYCLES),
  .SHORT_PULSE_CYCLES(SHORT_PULSE_CYCLES), .LONG_PULSE_CYCLES(LONG_PULSE_CYCLES)) chk_u (.*);
